// ===== include/frc_pkg.sv
// Constants, register map and types for the fault resequence controller.
// Assumes a 10 MHz clock and an APB register bus with 32-bit data.
package frc_pkg;
   localparam int NRAILS = 12;
   localparam int CLK_HZ = 10_000_000;
   localparam int STEP_MS = 5;
   localparam int STEP_CYC = CLK_HZ / 1000 * STEP_MS;
   localparam int STABLE_MS = 1000;
   localparam int STABLE_CYC = CLK_HZ / 1000 * STABLE_MS;
   localparam int MAX_RETRY = 14;
   localparam int MAX_ATTEMPTS = 4;
   localparam int DELAY_STEPS_MAX = 255;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DELAY = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ = 8'h0C;
   localparam logic [7:0] ADDR_MASK = 8'h10;
   localparam logic [7:0] ADDR_SLAVE0 = 8'h40;
   localparam logic [7:0] ADDR_MODE0 = 8'h80;
   // Control fields
   localparam int CTRL_ATT_LSB = 0;
   localparam int CTRL_CONT_BIT = 2;
   localparam int CTRL_EN_BIT = 3;
   // Per-rail mode fields and control reset value
   localparam int MODE_RETRY_LSB = 0;
   localparam int MODE_RESEQ_BIT = 4;
   localparam int MODE_DELAYED_BIT = 5;
   localparam logic [31:0] CTRL_RST = 32'h0000_000B;
   // Interrupt bits
   localparam int IRQ_START = 0;
   localparam int IRQ_TOFF_ERR = 1;
   localparam int IRQ_GIVEUP = 2;
   localparam int IRQ_CLEAR = 3;
   localparam int NIRQ = 4;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OFF = 3'b001,
      ST_DELAY = 3'b010,
      ST_ON = 3'b011,
      ST_STABLE = 3'b100,
      ST_HALT = 3'b101
   } frc_state_t;
endpackage

// ===== design/frc_timer.sv
// Down-counting timer for delay and stable periods.
// Assumes load and count requests from the controller in one clock domain.
`timescale 1ns/1ps
`default_nettype none
module frc_timer #(
   parameter int W = 24
) (
   input wire logic clk, // Clock
   input wire logic rst_n, // Async reset, active low
   input wire logic load, // Load count
   input wire logic [W-1:0] loadVal, // Count to load
   input wire logic run, // Count down while high
   output logic done // Count at zero
);
   logic [W-1:0] cnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt_q <= '0;
      else if (load) cnt_q <= loadVal;
      else if (run && cnt_q != '0) cnt_q <= cnt_q - W'(1);
   end
   assign done = (cnt_q == '0);
endmodule // frc_timer
`default_nettype wire

// ===== design/frc_controller.sv
// Fault resequence controller with APB registers and interrupt.
// Assumes rail status and fault inputs synchronous to clk; the rail
// sequencer outside honours shutdown and start requests.
`timescale 1ns/1ps
`default_nettype none
module frc_controller import frc_pkg::*; #(
   parameter int N = NRAILS,
   parameter int STEP_CYCLES = STEP_CYC,
   parameter int STABLE_CYCLES = STABLE_CYC
) (
   input wire logic clk, // 10 MHz clock
   input wire logic rst_n, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic [N-1:0] railFault, // Fault pulse per rail
   input wire logic [N-1:0] railOff, // Rail below off threshold
   input wire logic [N-1:0] railGood, // Rail in regulation
   input wire logic [N-1:0] offWarn, // turn_off_max_warning_limit hit
   output logic [N-1:0] railRetry, // Restart pulse for retrying rail
   output logic [N-1:0] stopNow, // Immediate shutdown request
   output logic [N-1:0] stopDelayed, // Shutdown after off delay
   output logic [N-1:0] seqOn, // Start-up sequence request
   output logic busy, // Resequence in progress
   output logic irq // Interrupt, active high
);
   localparam int TW = 24;
   frc_state_t state_q, state_d;
   logic [31:0] ctrl_q;
   logic [7:0] delay_q;
   logic [N-1:0] slave_q [N];
   logic [5:0] mode_q [N];
   logic [3:0] retry_q [N];
   logic [N-1:0] set_q, setImm_q;
   logic [2:0] attempts_q;
   logic [NIRQ-1:0] irqSt_q, irqMask_q, irqSet;
   logic [N-1:0] stopNow_q, stopDel_q, seqOn_q, retryP_q;
   logic [31:0] prdata_q;
   logic toffErr_q;

   // APB decode
   wire wrEn = psel && penable && pwrite;
   wire rdEn = psel && penable && !pwrite;
   wire inSlave = paddr >= ADDR_SLAVE0 && paddr < ADDR_SLAVE0 + 8'(4 * N);
   wire inMode = paddr >= ADDR_MODE0 && paddr < ADDR_MODE0 + 8'(4 * N);
   wire [3:0] slvIdx = 4'((paddr - ADDR_SLAVE0) >> 2);
   wire [3:0] modIdx = 4'((paddr - ADDR_MODE0) >> 2);
   wire mapped = paddr[1:0] == 2'b00 && (inSlave || inMode || paddr == ADDR_CTRL ||
      paddr == ADDR_DELAY || paddr == ADDR_STATUS || paddr == ADDR_IRQ || paddr == ADDR_MASK);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_q;

   wire [2:0] attLimit = 3'(ctrl_q[CTRL_ATT_LSB +: 2]) + 3'd1;
   wire contOnErr = ctrl_q[CTRL_CONT_BIT];
   wire enabled = ctrl_q[CTRL_EN_BIT];

   // Fault triage per rail
   logic [N-1:0] reseqReq, joinSet, joinImm, slavesOfSet;
   always_comb begin
      reseqReq = '0;
      joinSet = '0;
      joinImm = '0;
      slavesOfSet = '0;
      for (int i = 0; i < N; i++) begin
         if (set_q[i]) slavesOfSet = slavesOfSet | slave_q[i];
      end
      for (int i = 0; i < N; i++) begin
         // Faults on rails already in the set are not acted on
         if (railFault[i] && !set_q[i] && !(busy && slavesOfSet[i]) && enabled &&
             mode_q[i][MODE_RESEQ_BIT] && retry_q[i] == 4'(mode_q[i][MODE_RETRY_LSB +: 4])) begin
            reseqReq[i] = 1'b1;
            joinSet = joinSet | slave_q[i] | (N'(1) << i);
            // Slaves inherit the faulted rail's stop style
            if (!mode_q[i][MODE_DELAYED_BIT]) joinImm = joinImm | slave_q[i] | (N'(1) << i);
         end
      end
   end
   wire anyReq = |reseqReq;
   wire [N-1:0] unionSet = set_q | joinSet;
   wire allOff = &(railOff | ~unionSet);
   wire allGood = &(railGood | ~set_q);
   wire setFault = |(railFault & set_q);
   wire toffHit = |(offWarn & set_q);
   assign busy = state_q != ST_IDLE;

   // Timer shared by delay and stable periods
   logic tmrLoad, tmrDone;
   logic [TW-1:0] tmrVal;
   always_comb begin
      tmrLoad = 1'b0;
      tmrVal = '0;
      if (state_q == ST_OFF && state_d == ST_DELAY) begin
         tmrLoad = 1'b1;
         tmrVal = TW'(delay_q) * TW'(STEP_CYCLES);
      end else if (state_q == ST_ON && state_d == ST_STABLE) begin
         tmrLoad = 1'b1;
         tmrVal = TW'(STABLE_CYCLES);
      end
   end
   frc_timer #(.W(TW)) uTimer (
      .clk(clk),
      .rst_n(rst_n),
      .load(tmrLoad),
      .loadVal(tmrVal),
      .run(state_q == ST_DELAY || state_q == ST_STABLE),
      .done(tmrDone)
   );

   // Sequencing state machine
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: if (anyReq) state_d = ST_OFF;
         ST_OFF: begin
            // A joining set extends the off wait
            if (toffHit && !contOnErr && !toffErr_q) state_d = ST_HALT;
            else if (allOff && !anyReq) state_d = ST_DELAY;
         end
         ST_DELAY: if (tmrDone && !tmrLoad) state_d = ST_ON;
         ST_ON: begin
            if (allGood) state_d = ST_STABLE;
            else if (setFault) state_d = attempts_q >= attLimit ? ST_HALT : ST_OFF;
         end
         ST_STABLE: begin
            if (setFault || !allGood) state_d = attempts_q >= attLimit ? ST_HALT : ST_OFF;
            else if (tmrDone && !tmrLoad) state_d = ST_IDLE;
         end
         ST_HALT: state_d = ST_HALT;
         default: state_d = ST_IDLE;
      endcase
      if (anyReq && state_q != ST_IDLE && state_q != ST_HALT && state_q != ST_OFF &&
          attempts_q < attLimit) state_d = ST_OFF;
   end

   // Interrupt events
   always_comb begin
      irqSet = '0;
      irqSet[IRQ_START] = state_q == ST_IDLE && state_d == ST_OFF;
      irqSet[IRQ_TOFF_ERR] = state_q == ST_OFF && toffHit && !toffErr_q;
      irqSet[IRQ_GIVEUP] = state_d == ST_HALT && state_q != ST_HALT;
      irqSet[IRQ_CLEAR] = state_q == ST_STABLE && state_d == ST_IDLE;
   end
   assign irq = |(irqSt_q & irqMask_q);

   wire enterOff = state_d == ST_OFF && state_q != ST_OFF;
   wire rdIrq = rdEn && paddr == ADDR_IRQ;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         set_q <= '0;
         setImm_q <= '0;
         attempts_q <= '0;
         toffErr_q <= 1'b0;
         irqSt_q <= '0;
      end else begin
         state_q <= state_d;
         // Set-wins over read clear
         irqSt_q <= (rdIrq ? '0 : irqSt_q) | irqSet;
         if (state_q == ST_OFF && toffHit) toffErr_q <= 1'b1;
         else if (state_q != ST_OFF) toffErr_q <= 1'b0;
         if (state_d == ST_IDLE || state_d == ST_HALT && state_q == ST_HALT) begin
            set_q <= state_d == ST_IDLE ? '0 : set_q;
            setImm_q <= state_d == ST_IDLE ? '0 : setImm_q;
            attempts_q <= state_d == ST_IDLE ? '0 : attempts_q;
         end else begin
            set_q <= unionSet;
            setImm_q <= setImm_q | joinImm;
            // Shared count; a joining set does not restart it
            if (enterOff && state_q != ST_IDLE || state_q == ST_IDLE && anyReq)
               attempts_q <= attempts_q + 3'd1;
         end
      end
   end

   // Outputs to rail sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stopNow_q <= '0;
         stopDel_q <= '0;
         seqOn_q <= '0;
         retryP_q <= '0;
      end else begin
         stopNow_q <= state_d == ST_OFF || state_d == ST_HALT ? unionSet & (setImm_q | joinImm) : '0;
         stopDel_q <= state_d == ST_OFF || state_d == ST_HALT ? unionSet & ~(setImm_q | joinImm) : '0;
         seqOn_q <= state_d == ST_ON || state_d == ST_STABLE ? set_q : '0;
         for (int i = 0; i < N; i++)
            retryP_q[i] <= railFault[i] && !busy && mode_q[i][MODE_RESEQ_BIT] &&
                           retry_q[i] != 4'(mode_q[i][MODE_RETRY_LSB +: 4]);
      end
   end
   assign stopNow = stopNow_q;
   assign stopDelayed = stopDel_q;
   assign seqOn = seqOn_q;
   assign railRetry = retryP_q;

   // Retry counters per rail
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < N; i++) retry_q[i] <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (retryP_q[i]) retry_q[i] <= retry_q[i] + 4'd1;
            else if (state_q == ST_STABLE && state_d == ST_IDLE) retry_q[i] <= '0;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RST;
         delay_q <= '0;
         irqMask_q <= '0;
         for (int i = 0; i < N; i++) begin
            slave_q[i] <= '0;
            mode_q[i] <= '0;
         end
      end else if (wrEn) begin
         if (paddr == ADDR_CTRL) ctrl_q <= {28'h0000000, pwdata[3:0]};
         if (paddr == ADDR_DELAY) delay_q <= pwdata[7:0];
         if (paddr == ADDR_MASK) irqMask_q <= pwdata[NIRQ-1:0];
         if (inSlave) slave_q[slvIdx] <= pwdata[N-1:0];
         if (inMode) mode_q[modIdx] <= pwdata[5:0];
      end
   end

   // Read data mux
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0000_0000;
      if (paddr == ADDR_CTRL) rdMux = ctrl_q;
      else if (paddr == ADDR_DELAY) rdMux = {24'h000000, delay_q};
      else if (paddr == ADDR_STATUS)
         rdMux = {1'b0, state_q, 1'b0, attempts_q, toffErr_q, 3'b000, 4'h0, (16 - N)'(0), set_q};
      else if (paddr == ADDR_IRQ) rdMux = {28'h0000000, irqSt_q};
      else if (paddr == ADDR_MASK) rdMux = {28'h0000000, irqMask_q};
      else if (inSlave) rdMux = {(32 - N)'(0), slave_q[slvIdx]};
      else if (inMode) rdMux = {26'h0, mode_q[modIdx]};
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) prdata_q <= '0;
      else if (psel && !penable && !pwrite) prdata_q <= rdMux;
   end
endmodule // frc_controller
`default_nettype wire

// ===== testbench/frc_controller_asserts.sv
// Port checker for frc_controller.
// Bound into every frc_controller instance.
`timescale 1ns/1ps
`default_nettype none
module frc_controller_asserts #(
   parameter int N = 12,
   parameter int STEP_CYCLES = 4,
   parameter int STABLE_CYCLES = 50
) (
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic [N-1:0] railFault, // Fault per rail
   input wire logic [N-1:0] railOff, // Rail off
   input wire logic [N-1:0] railGood, // Rail regulated
   input wire logic [N-1:0] offWarn, // Turn-off limit hit
   input wire logic [N-1:0] railRetry, // Restart pulse
   input wire logic [N-1:0] stopNow, // Immediate stop
   input wire logic [N-1:0] stopDelayed, // Delayed stop
   input wire logic [N-1:0] seqOn, // Start request
   input wire logic busy, // Resequence active
   input wire logic irq // Interrupt
);
   logic [31:0] goodCnt_q;
   wire anyFault = |railFault;
   wire offPending = |((stopNow | stopDelayed) & ~railOff);
   wire allGood = busy && |seqOn && ((seqOn & ~railGood) == '0);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) goodCnt_q <= '0;
      else goodCnt_q <= allGood ? goodCnt_q + 32'h1 : '0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_stop_while_busy: assert property ((|stopNow || |stopDelayed) |-> busy) else $error("stop outside run");
   a_start_stops: assert property ($rose(busy) |-> (|stopNow || |stopDelayed)) else $error("run without stop");
   a_start_cause: assert property ($rose(busy) |-> $past(anyFault)) else $error("run without fault");
   a_stop_one_kind: assert property ((stopNow & stopDelayed) == '0) else $error("two stop kinds");
   a_no_on_in_off: assert property ((seqOn & (stopNow | stopDelayed)) == '0) else $error("on while stopping");
   a_on_after_off: assert property ($rose(|seqOn) |-> !$past(offPending)) else $error("on before all off");
   a_retry_cause: assert property (|railRetry |-> $past(anyFault)) else $error("retry without fault");
   a_stable_second: assert property ((rst_n && $fell(busy)) |-> $past(goodCnt_q) >= STABLE_CYCLES - 1)
      else $error("idle before stable period");
   a_reset_idle: assert property ($rose(rst_n) |-> !busy && seqOn == '0 && stopNow == '0)
      else $error("not idle after reset");
   c_retry: cover property (|railRetry);
   c_on: cover property ($rose(|seqOn));
   c_done: cover property ($fell(busy));
endmodule // frc_controller_asserts
bind frc_controller frc_controller_asserts #(.N(N), .STEP_CYCLES(STEP_CYCLES), .STABLE_CYCLES(STABLE_CYCLES))
   u_frc_controller_asserts (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .railFault, .railOff, .railGood, .offWarn, .railRetry, .stopNow, .stopDelayed, .seqOn, .busy, .irq);
`default_nettype wire

// ===== testbench/frc_rail_model.sv
// Behavioural rails behind the enable outputs.
// Rails start regulated; slow makes them react every eighth cycle.
`timescale 1ns/1ps
`default_nettype none
module frc_rail_model #(
   parameter int N = 12
) (
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic slow, // Slow reaction
   input wire logic [N-1:0] stop, // Shutdown request
   input wire logic [N-1:0] on, // Start request
   output logic [N-1:0] railOff, // Rail discharged
   output logic [N-1:0] railGood // Rail regulated
);
   logic [2:0] tick_q;
   wire step = !slow || tick_q == 3'h0;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q <= 3'h0;
         railOff <= '0;
         railGood <= '1;
      end else begin
         tick_q <= tick_q + 3'h1;
         if (step) begin
            railOff <= (railOff | stop) & ~on;
            railGood <= (railGood & ~stop) | on;
         end
      end
   end
endmodule // frc_rail_model
`default_nettype wire

// ===== testbench/fault_resequence_controller_bench.sv
// Self-checking bench for frc_controller with a rail model.
// Short timer parameters keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module fault_resequence_controller_bench;
   import frc_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [11:0] railFault = 12'h000, offWarn = 12'h000, slaves;
   logic [31:0] prdata;
   logic [11:0] railRetry, stopNow, stopDelayed, seqOn, railOff, railGood;
   logic pready, pslverr, busy, irq;
   logic [32:0] notes[$];
   int bad_count = 0, total_checks = 0;
   frc_controller #(.N(12), .STEP_CYCLES(4), .STABLE_CYCLES(50)) u_frc_controller (.clk, .rst_n, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .railFault, .railOff, .railGood,
      .offWarn, .railRetry, .stopNow, .stopDelayed, .seqOn, .busy, .irq);
   frc_rail_model #(.N(12)) u_frc_rail_model (.clk, .rst_n, .slow, .stop(stopNow | stopDelayed), .on(seqOn),
      .railOff, .railGood);
   always #50 clk = ~clk;
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
      int n = 0;
      if (!wr) notes.push_back(exp);
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20) begin
         bad_count++;
         final_report();
      end
      {psel, penable} <= 2'b00;
      @(posedge clk);
   endtask
   // Read results compared against the oldest note
   always @(posedge clk) begin
      if (psel && penable && !pwrite && pready) chk({pslverr, prdata}, notes.pop_front());
   end
   task automatic waitFor(input int k);
      int n = 0;
      while (!(k == 0 ? busy === 1'b0 : seqOn !== 12'h000)) begin
         @(posedge clk);
         #1;
         if (++n > 2000) begin
            bad_count++;
            final_report();
         end
      end
   endtask
   task automatic fault(input logic [11:0] f);
      @(posedge clk);
      railFault <= f;
      @(posedge clk);
      railFault <= 12'h000;
      #1;
   endtask
   initial begin
      void'($urandom(87742));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      slaves = (12'($urandom) & 12'hFFE) | 12'h004;
      apb(0, ADDR_CTRL, 0, {1'b0, CTRL_RST});
      apb(0, 8'hFC, 0, 33'h1_0000_0000);
      apb(1, ADDR_MASK, 32'h0000_000F, 0);
      apb(1, ADDR_DELAY, 32'h0000_0002, 0);
      apb(1, ADDR_MODE0, 32'h0000_0012, 0);
      apb(1, ADDR_SLAVE0, {20'h0, slaves}, 0);
      apb(1, ADDR_MODE0 + 8'h0C, 32'h0000_0030, 0);
      apb(1, ADDR_SLAVE0 + 8'h0C, 32'h0000_0010, 0);
      apb(1, ADDR_MODE0 + 8'h14, 32'h0000_0010, 0);
      apb(1, ADDR_SLAVE0 + 8'h14, 32'h0000_0040, 0);
      fault(12'h001);
      chk({busy, railRetry}, 13'h001);
      fault(12'h001);
      chk({busy, railRetry}, 13'h001);
      fault(12'h001);
      chk({stopDelayed, stopNow}, {12'h000, slaves | 12'h001});
      chk(irq, 1'b1);
      apb(0, ADDR_IRQ, 0, 33'h1);
      fault(slaves);
      chk({busy, railRetry, stopNow}, {1'b1, 12'h000, 12'h000});
      waitFor(1);
      chk(seqOn, slaves | 12'h001);
      waitFor(0);
      apb(0, ADDR_IRQ, 0, 33'h8);
      apb(1, ADDR_CTRL, 32'h0000_0008, 0);
      slow <= 1'b1;
      fault(12'h008);
      chk({stopNow, stopDelayed}, {12'h000, 12'h018});
      fault(12'h020);
      chk({seqOn, stopNow | stopDelayed}, {12'h000, 12'h078});
      waitFor(1);
      chk(seqOn, 12'h078);
      repeat (20) @(posedge clk);
      fault(12'h008);
      apb(0, ADDR_IRQ, 0, 33'h5);
      chk(busy, 1'b1);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk({busy, seqOn, stopNow}, 25'h0);
      apb(1, ADDR_MODE0 + 8'h0C, 32'h0000_0030, 0);
      apb(1, ADDR_MASK, 32'h0000_000F, 0);
      offWarn <= 12'h008;
      fault(12'h008);
      @(posedge clk);
      offWarn <= 12'h000;
      apb(1, ADDR_MASK, 32'h0000_0000, 0);
      chk(irq, 1'b0);
      apb(1, ADDR_MASK, 32'h0000_000F, 0);
      apb(0, ADDR_IRQ, 0, 33'h7);
      repeat (60) @(posedge clk);
      chk({busy, seqOn}, 13'h1000);
      // Continue-on-error option with zero delay
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      slow <= 1'b0;
      apb(1, ADDR_CTRL, 32'h0000_000C, 0);
      apb(1, ADDR_MODE0 + 8'h0C, 32'h0000_0030, 0);
      offWarn <= 12'h008;
      fault(12'h008);
      @(posedge clk);
      offWarn <= 12'h000;
      waitFor(1);
      chk(seqOn, 12'h008);
      apb(0, ADDR_IRQ, 0, 33'h3);
      final_report();
   end
endmodule // fault_resequence_controller_bench
`default_nettype wire
